// ### sim/bus_far_master.sv
/* bus_far_master: behavioural master on the two-wire bus, bit-banged on sys_clk.
   assumes pull-ups on both wires and the resolved wire levels fed back in. */
`timescale 1ns/1ns
module bus_far_master import i2c_pkg::*; (
  input wire logic sys_clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe,
  output logic stuck
);
  localparam int half = 6;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    stuck = 1'b0;
  end
  task automatic pause();
    repeat (half) @(posedge sys_clk);
  endtask : pause
  // a slave may stretch, so follow the wire; bounded so a stuck clock shows up
  task automatic rise();
    int n;
    n = 0;
    scl_oe <= 1'b0;
    @(posedge sys_clk);
    while (scl !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 400) begin
      stuck <= 1'b1;
    end
    pause();
  endtask : rise
  task automatic start();
    @(posedge sys_clk);
    sda_oe <= 1'b1;
    pause();
    scl_oe <= 1'b1;
    pause();
  endtask : start
  // data changes at least one cycle after the clock fall, never beside it
  task automatic send_byte(input byte_t b, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      @(posedge sys_clk);
      sda_oe <= !b[i];
      pause();
      rise();
      scl_oe <= 1'b1;
    end
    @(posedge sys_clk);
    sda_oe <= 1'b0;
    pause();
    rise();
    nack = sda;
    scl_oe <= 1'b1;
  endtask : send_byte
  // single-byte read: the acknowledge bit is left released
  task automatic recv_byte(output byte_t b);
    @(posedge sys_clk);
    sda_oe <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pause();
      rise();
      b[i] = sda;
      scl_oe <= 1'b1;
    end
    pause();
    rise();
    scl_oe <= 1'b1;
  endtask : recv_byte
  task automatic stop();
    @(posedge sys_clk);
    sda_oe <= 1'b1;
    pause();
    rise();
    sda_oe <= 1'b0;
    pause();
  endtask : stop
endmodule : bus_far_master

// ### sim/tb_top.sv
/* tb_top: register, interrupt and slave-transfer checks of i2c_config_regs.
   assumes the far master model and pull-ups resolved here from both enables. */
`timescale 1ns/1ns
`include "i2c_defines.svh"
module tb_top import i2c_pkg::*; ;
  typedef struct packed {
    byte_t val;
    byte_t mask;
  } note_t;
  logic sys_clk;
  logic reset_n;
  byte_t reg_addr;
  byte_t reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic scl_out, scl_oe, sda_out, sda_oe, irq;
  logic m_scl_oe, m_sda_oe, stuck;
  wire scl_w = !(scl_oe || m_scl_oe);
  wire sda_w = !(sda_oe || m_sda_oe);
  note_t notes[$];
  note_t cur;
  logic rd_seen = 1'b0;
  int miscompares = 0;
  int checks = 0;
  int seed = 22557;
  byte_t r_clk, r_high, r_data;
  i2c_config_regs u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
  bus_far_master u_far (.sys_clk(sys_clk), .scl(scl_w), .sda(sda_w),
    .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .stuck(stuck));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic end_sim();
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input byte_t a, input byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // the note goes in first; the watcher takes it when the data stand
  task automatic rd(input byte_t a, input byte_t e, input byte_t m);
    notes.push_back({e, m});
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  always @(posedge sys_clk) begin
    if (rd_seen === 1'b1) begin
      cur = notes.pop_front();
      cmp(reg_rdata & cur.mask, cur.val & cur.mask);
    end
    rd_seen <= reg_rd;
  end
  initial begin
    repeat (6000) @(posedge sys_clk);
    miscompares++;
    end_sim();
  end
  initial begin
    int n;
    logic nack;
    byte_t got;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int a = 8'h64; a <= 8'h6d; a++) begin
      rd(8'(a), (a == 8'h69) ? `RST_OWN_HIGH : `RST_ZERO, 8'hff);
    end
    wr(8'h70, 8'hff);
    rd(8'h70, 8'h00, 8'hff);
    r_clk = 8'($random(seed));
    r_high = 8'($random(seed));
    wr(`OFF_CLK, r_clk);
    rd(`OFF_CLK, r_clk, 8'hff);
    wr(`OFF_OWN_HIGH, r_high);
    r_high = r_high & 8'hc6;
    rd(`OFF_OWN_HIGH, r_high, 8'hff);
    wr(`OFF_STAT_ERR, 8'hff);
    rd(`OFF_STAT_ERR, 8'h00, 8'he6);
    wr(`OFF_CTRL, 8'h25);
    rd(`OFF_CTRL, 8'h25, `CTRL_MASK);
    // range bits are frozen while the interface is on, address bits are not
    wr(`OFF_OWN_HIGH, 8'h3e);
    r_high = (r_high & `OWN_RANGE_MASK) | 8'h06;
    rd(`OFF_OWN_HIGH, r_high, 8'hff);
    wr(`OFF_OWN_LOW, 8'ha5);
    u_far.start();
    u_far.send_byte(8'ha4, nack);
    cmp({7'h00, nack}, 8'h00);
    cmp({7'h00, irq}, 8'h00);
    wr(`OFF_IRQ_MASK, 8'h02);
    r_data = 8'($random(seed));
    u_far.send_byte(r_data, nack);
    cmp({7'h00, nack}, 8'h00);
    repeat (4) @(posedge sys_clk);
    cmp({7'h00, scl_oe}, 8'h01);
    cmp({7'h00, irq}, 8'h01);
    // a buffer read with no status read before it must not release the clock
    rd(`OFF_DBUF, r_data, 8'hff);
    repeat (4) @(posedge sys_clk);
    cmp({7'h00, scl_oe}, 8'h01);
    rd(`OFF_STAT_MAIN, 8'h08, 8'h08);
    rd(`OFF_IRQ_STAT, 8'h06, 8'h06);
    repeat (2) @(posedge sys_clk);
    cmp({7'h00, irq}, 8'h00);
    rd(`OFF_DBUF, r_data, 8'hff);
    n = 0;
    while (scl_oe !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    cmp({7'h00, scl_oe}, 8'h00);
    rd(`OFF_STAT_MAIN, 8'h00, 8'h08);
    u_far.stop();
    u_far.start();
    u_far.send_byte(8'ha5, nack);
    cmp({7'h00, nack}, 8'h00);
    r_data = 8'($random(seed));
    wr(`OFF_DBUF, r_data);
    u_far.recv_byte(got);
    cmp(got, r_data);
    // switching off releases both lines so the master can close the frame
    wr(`OFF_CTRL, 8'h00);
    u_far.stop();
    wr(`OFF_CTRL, 8'h24);
    wr(`OFF_OWN_LOW, `BAD_OWN);
    u_far.start();
    u_far.send_byte(8'h01, nack);
    cmp({7'h00, nack}, 8'h01);
    u_far.stop();
    // own start: one half period of the divider at most, then start-sent holds
    wr(`OFF_CTRL, 8'h2c);
    repeat (300) @(posedge sys_clk);
    rd(`OFF_STAT_MAIN, 8'h03, 8'h03);
    wr(`OFF_CTRL, 8'h00);
    rd(`OFF_CLK, r_clk, 8'hff);
    rd(`OFF_OWN_LOW, `BAD_OWN, 8'hff);
    rd(`OFF_OWN_HIGH, r_high, 8'hff);
    cmp({7'h00, stuck}, 8'h00);
    repeat (2) @(posedge sys_clk);
    end_sim();
  end
endmodule : tb_top

// ### verilog/i2c_config_regs.sv
/* i2c_config_regs: registers, own-address match and byte engine of a
   multimaster two-wire interface. assumes pins synchronous to sys_clk and
   an open-drain wire resolved outside from the enables. */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`include "i2c_defines.svh"
module i2c_config_regs import i2c_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);
  byte_t ctrl, clk_setup, own_low, own_high, dbuf;
  byte_t next_ctrl, next_clk_setup, next_own_low, next_own_high, next_dbuf, next_rdata;
  logic [`EV_W-1:0] irq_st, irq_mask, next_irq_st, next_irq_mask, ev;
  eng_state_t state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [1:0] addr_ph, next_addr_ph;
  logic addr_mode, tx, master, busy, byte_done, start_sent, adsl, af, stopf, gcal;
  logic next_addr_mode, next_tx, next_master, next_busy, next_byte_done;
  logic next_start_sent, next_adsl, next_af, next_stopf, next_gcal;
  logic sr1_seen, ten_hit, nack, scl_prev, sda_prev;
  logic next_sr1_seen, next_ten_hit, next_nack, next_scl_oe, next_sda_oe, next_irq;
  logic on, scl_rise, scl_fall, bus_start, bus_stop, wr_dbuf, rd_dbuf, rd_main;
  logic rd_err, rd_irq, hit7, hit_gc, hdr, hit10lo, addr_ok, wr_go, rd_go, evf;
  scl_tick_if tk();

  scl_tick_gen u_tick (.sys_clk(sys_clk), .reset_n(reset_n), .t(tk.gen));

  assign tk.fast = clk_setup[`CLK_FAST];
  assign tk.divider = clk_setup[6:0];
  assign tk.run = master && (state != ST_IDLE) && (state != ST_HOLD);

  assign on = ctrl[`CTRL_ON];
  assign scl_rise = scl_in && !scl_prev;
  assign scl_fall = !scl_in && scl_prev;
  assign bus_start = scl_in && scl_prev && sda_prev && !sda_in;
  assign bus_stop = scl_in && scl_prev && !sda_prev && sda_in;
  assign wr_dbuf = reg_wr && reg_addr == `OFF_DBUF;
  assign rd_dbuf = reg_rd && reg_addr == `OFF_DBUF;
  assign rd_main = reg_rd && reg_addr == `OFF_STAT_MAIN;
  assign rd_err = reg_rd && reg_addr == `OFF_STAT_ERR;
  assign rd_irq = reg_rd && reg_addr == `OFF_IRQ_STAT;
  // the direction bit of the own address never takes part
  assign hit7 = !addr_mode && own_low != `BAD_OWN && dbuf[7:1] == own_low[7:1];
  assign hit_gc = ctrl[`CTRL_GC] && dbuf == `GEN_CALL;
  assign hdr = addr_mode && dbuf[7:1] == {`TEN_HDR, own_high[2:1]};
  assign hit10lo = dbuf == own_low;
  assign addr_ok = (addr_ph == 2'h1) ? (hit7 || hit_gc || hdr) : hit10lo;
  assign wr_go = wr_dbuf && (tx || start_sent)
                 && (sr1_seen || !(start_sent || byte_done));
  assign rd_go = rd_dbuf && !tx && sr1_seen && byte_done;
  assign evf = byte_done || adsl || start_sent || af || stopf;

  always_comb begin
    next_ctrl = ctrl;
    next_clk_setup = clk_setup;
    next_own_low = own_low;
    next_own_high = own_high;
    next_dbuf = dbuf;
    next_irq_mask = irq_mask;
    next_addr_mode = addr_mode;
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_addr_ph = addr_ph;
    next_tx = tx;
    next_master = master;
    next_busy = busy;
    next_byte_done = byte_done;
    next_start_sent = start_sent;
    next_adsl = adsl;
    next_af = af;
    next_stopf = stopf;
    next_gcal = gcal;
    next_sr1_seen = sr1_seen;
    next_ten_hit = ten_hit;
    next_nack = nack;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    ev = '0;
    if (reg_wr) begin
      case (reg_addr)
        `OFF_CTRL: next_ctrl = reg_wdata & `CTRL_MASK;
        `OFF_CLK: next_clk_setup = reg_wdata;
        `OFF_OWN_LOW: next_own_low = reg_wdata;
        // range bits only move while the interface is off
        `OFF_OWN_HIGH: next_own_high = on
            ? ((reg_wdata & `OWN_ADDR_MASK) | (own_high & `OWN_RANGE_MASK))
            : (reg_wdata & (`OWN_ADDR_MASK | `OWN_RANGE_MASK));
        `OFF_DBUF: next_dbuf = reg_wdata;
        `OFF_IRQ_MASK: next_irq_mask = reg_wdata[`EV_W-1:0];
        `OFF_MODE: next_addr_mode = reg_wdata[0];
        default: next_addr_mode = addr_mode;
      endcase
    end
    if (wr_dbuf || rd_dbuf) begin
      next_sr1_seen = 1'b0;
    end
    if (rd_main) begin
      next_sr1_seen = 1'b1;
      next_adsl = 1'b0;
    end
    if (rd_err) begin
      next_af = 1'b0;
      next_stopf = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        if (on && ctrl[`CTRL_START] && !busy) begin
          next_state = ST_START;
          next_master = 1'b1;
          next_sda_oe = 1'b1;
        end
      end
      ST_START: begin
        if (tk.tick) begin
          next_scl_oe = 1'b1;
          next_start_sent = 1'b1;
          next_ctrl[`CTRL_START] = 1'b0;
          next_busy = 1'b1;
          ev[`EV_START] = 1'b1;
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        next_scl_oe = 1'b1;
        if (master && ctrl[`CTRL_STOP] && !start_sent) begin
          next_state = ST_STOP;
          next_sda_oe = 1'b1;
        end else if (wr_go) begin
          next_addr_ph = start_sent ? 2'h1 : 2'h0;
          next_start_sent = 1'b0;
          next_byte_done = 1'b0;
          next_tx = 1'b1;
          next_bit_cnt = 4'h0;
          next_sda_oe = !reg_wdata[7];
          next_scl_oe = master;
          next_state = ST_SHIFT;
        end else if (rd_go) begin
          next_byte_done = 1'b0;
          next_bit_cnt = 4'h0;
          next_scl_oe = master;
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT, ST_ACK: begin
        // a slave stretching the clock keeps it low until it lets go
        if (master && tk.tick) begin
          next_scl_oe = !scl_oe && scl_in;
        end
        if (state == ST_SHIFT && scl_rise) begin
          next_bit_cnt = bit_cnt + 4'h1;
          if (!tx) begin
            next_dbuf = {dbuf[6:0], sda_in};
          end
        end
        if (state == ST_SHIFT && scl_fall) begin
          if (tx) begin
            next_dbuf = {dbuf[6:0], dbuf[7]};
            next_sda_oe = !dbuf[6];
          end
          if (bit_cnt == `LAST_BIT) begin
            next_state = ST_ACK;
            next_sda_oe = !tx && ctrl[`CTRL_ACK] && (addr_ph == 2'h0 || addr_ok);
            if (!master && addr_ph != 2'h0 && !addr_ok) begin
              next_state = ST_IDLE;
            end
          end
        end
        if (state == ST_ACK && scl_rise) begin
          next_nack = tx && sda_in;
          if (tx && sda_in) begin
            next_af = 1'b1;
            ev[`EV_NACK] = 1'b1;
          end
        end
        if (state == ST_ACK && scl_fall) begin
          next_sda_oe = 1'b0;
          next_bit_cnt = 4'h0;
          next_addr_ph = 2'h0;
          next_state = ST_HOLD;
          if (master && !nack && addr_ph == 2'h1 && dbuf[0]) begin
            next_tx = 1'b0;
            next_state = ST_SHIFT;
          end else if (master || (addr_ph == 2'h0 && !nack)) begin
            next_byte_done = 1'b1;
            ev[`EV_DONE] = 1'b1;
          end else if (addr_ph == 2'h0) begin
            next_scl_oe = 1'b0;
            next_state = ST_IDLE;
          end else if (addr_ph == 2'h1 && hdr && !(ten_hit && dbuf[0])) begin
            next_addr_ph = 2'h2;
            next_state = ST_SHIFT;
          end else begin
            next_adsl = 1'b1;
            ev[`EV_MATCH] = 1'b1;
            next_gcal = addr_ph == 2'h1 && hit_gc;
            next_ten_hit = addr_ph == 2'h2 || ten_hit;
            next_tx = addr_ph == 2'h1 && dbuf[0];
            if (!(addr_ph == 2'h1 && dbuf[0])) begin
              next_state = ST_SHIFT;
            end
          end
        end
      end
      ST_STOP: begin
        if (tk.tick && scl_oe) begin
          next_scl_oe = 1'b0;
        end else if (tk.tick && scl_in) begin
          next_sda_oe = 1'b0;
          next_master = 1'b0;
          next_busy = 1'b0;
          next_tx = 1'b0;
          next_byte_done = 1'b0;
          next_ctrl[`CTRL_STOP] = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (bus_start && !master) begin
      next_busy = 1'b1;
      next_tx = 1'b0;
      next_bit_cnt = 4'h0;
      next_addr_ph = 2'h1;
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
      next_state = ST_SHIFT;
    end
    if (bus_stop && !master) begin
      next_busy = 1'b0;
      next_stopf = next_stopf || state != ST_IDLE;
      ev[`EV_STOP] = state != ST_IDLE;
      next_gcal = 1'b0;
      next_ten_hit = 1'b0;
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
      next_state = ST_IDLE;
    end
    // off clears engine and flags except interrupt status; speed, divider and addresses stay
    if (!on) begin
      next_state = ST_IDLE;
      next_master = 1'b0;
      next_busy = 1'b0;
      next_tx = 1'b0;
      next_byte_done = 1'b0;
      next_start_sent = 1'b0;
      next_adsl = 1'b0;
      next_af = 1'b0;
      next_stopf = 1'b0;
      next_gcal = 1'b0;
      next_sr1_seen = 1'b0;
      next_ten_hit = 1'b0;
      next_sda_oe = 1'b0;
      next_scl_oe = 1'b0;
      ev = '0;
    end
    if (!next_ctrl[`CTRL_ON]) begin
      next_ctrl[`CTRL_IRQ] = 1'b0;
    end
    // a read-clear in the same cycle as a new event keeps the event
    next_irq_st = (rd_irq ? '0 : irq_st) | ev;
    next_irq = |(next_irq_st & next_irq_mask) && next_ctrl[`CTRL_IRQ];
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `OFF_CTRL: next_rdata = ctrl;
        `OFF_STAT_MAIN: next_rdata = {evf, 1'b0, tx, busy, byte_done, adsl, master, start_sent};
        `OFF_STAT_ERR: next_rdata = {3'h0, af, stopf, 2'h0, gcal};
        `OFF_CLK: next_rdata = clk_setup;
        `OFF_OWN_LOW: next_rdata = own_low;
        `OFF_OWN_HIGH: next_rdata = own_high & (`OWN_ADDR_MASK | `OWN_RANGE_MASK);
        `OFF_DBUF: next_rdata = dbuf;
        `OFF_IRQ_STAT: next_rdata = {3'h0, irq_st};
        `OFF_IRQ_MASK: next_rdata = {3'h0, irq_mask};
        `OFF_MODE: next_rdata = {7'h00, addr_mode};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `RST_ZERO;
      clk_setup <= `RST_ZERO;
      own_low <= `RST_ZERO;
      own_high <= `RST_OWN_HIGH;
      dbuf <= `RST_ZERO;
      irq_st <= '0;
      irq_mask <= '0;
      addr_mode <= 1'b0;
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      addr_ph <= 2'h0;
      {tx, master, busy, byte_done, start_sent, adsl, af, stopf, gcal} <= '0;
      {sr1_seen, ten_hit, nack, scl_oe, sda_oe, irq} <= '0;
      {scl_out, sda_out} <= '0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      reg_rdata <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      clk_setup <= next_clk_setup;
      own_low <= next_own_low;
      own_high <= next_own_high;
      dbuf <= next_dbuf;
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
      addr_mode <= next_addr_mode;
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      addr_ph <= next_addr_ph;
      {tx, master, busy, byte_done} <= {next_tx, next_master, next_busy, next_byte_done};
      {start_sent, adsl, af, stopf, gcal} <= {next_start_sent, next_adsl, next_af,
                                              next_stopf, next_gcal};
      {sr1_seen, ten_hit, nack} <= {next_sr1_seen, next_ten_hit, next_nack};
      {scl_oe, sda_oe, irq} <= {next_scl_oe, next_sda_oe, next_irq};
      {scl_out, sda_out} <= '0;
      scl_prev <= scl_in;
      sda_prev <= sda_in;
      reg_rdata <= next_rdata;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence tx_release_s;
    state == ST_HOLD && tx && byte_done && sr1_seen && wr_dbuf && !ctrl[`CTRL_STOP] && on;
  endsequence
  sequence addr_read_s;
    state == ST_ACK && master && addr_ph == 2'h1 && dbuf[0] && !nack && scl_fall && on;
  endsequence
  speed_keep_a: assert property ($fell(on) |-> $stable(tk.fast))
    else $error("speed changed on disable");
  div_keep_a: assert property ($fell(on) |-> $stable(tk.divider))
    else $error("divider changed on disable");
  tx_go_a: assert property (tx_release_s |=> state == ST_SHIFT && sda_oe == !dbuf[7])
    else $error("buffer write did not start transmission");
  rx_auto_a: assert property (addr_read_s |=> state == ST_SHIFT && !tx)
    else $error("first byte not received after read address");
  dir_free_a: assert property (
    !addr_mode && own_low != `BAD_OWN && dbuf[7:1] == own_low[7:1] |-> hit7)
    else $error("direction bit affected match");
  addr_bad_a: assert property (own_low == `BAD_OWN |-> !hit7)
    else $error("address 01h matched");
  ten_hdr_a: assert property (
    addr_mode && dbuf[2:1] == own_high[2:1] && dbuf[7:3] == `TEN_HDR |-> hdr)
    else $error("ten-bit header missed");
  range_lock_a: assert property (
    on && reg_wr && reg_addr == `OFF_OWN_HIGH |=> $stable(own_high[7:6]))
    else $error("delay range written while enabled");
  reset_val_a: assert property ($rose(reset_n) |-> own_high == `RST_OWN_HIGH)
    else $error("own high reset value wrong");
  done_clear_a: assert property ($fell(byte_done) && $past(on) && on |->
    $past(sr1_seen) && $past(wr_dbuf || rd_dbuf))
    else $error("byte-done cleared without status read and buffer access");
  start_clear_a: assert property ($fell(start_sent) && on |->
    $past(sr1_seen) && $past(wr_dbuf))
    else $error("start-sent cleared without status read and buffer write");
  hold_low_a: assert property (byte_done && $past(byte_done) |-> scl_oe)
    else $error("clock released while byte-done set");
  resv_zero_a: assert property (reg_rd && reg_addr == `OFF_STAT_ERR |=>
    reg_rdata[7:5] == 3'h0 && reg_rdata[2:1] == 2'h0)
    else $error("reserved status bits not zero");
endmodule : i2c_config_regs

// ### verilog/i2c_defines.svh
/* i2c_defines: register offsets, field positions, reset values and event
   bit positions of the two-wire interface. assumes inclusion by bare name. */
`ifndef I2C_DEFINES_SVH
`define I2C_DEFINES_SVH
`define OFF_CTRL 8'h64
`define OFF_STAT_MAIN 8'h65
`define OFF_STAT_ERR 8'h66
`define OFF_CLK 8'h67
`define OFF_OWN_LOW 8'h68
`define OFF_OWN_HIGH 8'h69
`define OFF_DBUF 8'h6a
`define OFF_IRQ_STAT 8'h6b
`define OFF_IRQ_MASK 8'h6c
`define OFF_MODE 8'h6d
`define RST_ZERO 8'h00
`define RST_OWN_HIGH 8'h40
`define CTRL_ON 5
`define CTRL_GC 4
`define CTRL_START 3
`define CTRL_ACK 2
`define CTRL_STOP 1
`define CTRL_IRQ 0
`define CTRL_MASK 8'h3f
`define CLK_FAST 7
`define OWN_RANGE_MASK 8'hc0
`define OWN_ADDR_MASK 8'h06
`define GEN_CALL 8'h00
`define BAD_OWN 8'h01
`define TEN_HDR 5'h1e
`define LAST_BIT 4'h8
`define EV_START 0
`define EV_DONE 1
`define EV_MATCH 2
`define EV_NACK 3
`define EV_STOP 4
`define EV_W 5
`endif

// ### verilog/i2c_pkg.sv
/* i2c_pkg: types shared by the two-wire interface modules.
   assumes nothing of its surroundings. */
package i2c_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SHIFT = 3'h1,
    ST_ACK = 3'h3,
    ST_HOLD = 3'h2,
    ST_START = 3'h6,
    ST_STOP = 3'h4
  } eng_state_t;
  typedef logic [7:0] byte_t;
endpackage : i2c_pkg

// ### verilog/scl_tick_gen.sv
/* scl_tick_gen: one-cycle pulse per half period of the bus clock.
   assumes divider and speed are stable while run is high. */
`timescale 1ns/1ns
module scl_tick_gen import i2c_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset_n,
  scl_tick_if.gen t
);
  byte_t count, next_count, reload;
  logic next_tick;
  // standard speed doubles the half period, so one divider spans both modes
  assign reload = t.fast ? {1'b0, t.divider} : {t.divider, 1'b1};
  always_comb begin
    next_tick = 1'b0;
    next_count = reload;
    if (t.run && count != 8'h00) begin
      next_count = count - 8'h01;
    end else if (t.run) begin
      next_tick = 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 8'h00;
      t.tick <= 1'b0;
    end else begin
      count <= next_count;
      t.tick <= next_tick;
    end
  end
endmodule : scl_tick_gen

// ### verilog/scl_tick_if.sv
/* scl_tick_if: divider setting in, half-period tick out.
   assumes one clock shared by both ends. */
`timescale 1ns/1ns
interface scl_tick_if;
  logic [6:0] divider;
  logic fast;
  logic run;
  logic tick;
  modport gen (input divider, input fast, input run, output tick);
  modport user (output divider, output fast, output run, input tick);
endinterface : scl_tick_if
